// *** rtl/pcf_pkg.sv ***
// package: register map, routing codes and carrier types of the port c/d/e function select
`default_nettype none

package pcf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PCF_NPINS = 24;          // port c lines 0..7, d 8..15, e 16..23
  localparam int PCF_NSEL  = 6;           // select registers, four 2-bit fields each
  localparam int PCF_NSRC  = 15;          // peripheral signals that can drive a pin
  localparam int PCF_NIN   = 20;          // peripheral inputs fed from pins

  // ----------------------------------------------------------------
  // register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] PCF_OFS_SEL [PCF_NSEL] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
  localparam logic [4:0] PCF_OFS_LEVEL = 5'h18;   // synchronised pin levels, read only
  localparam logic [7:0] PCF_SEL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PCF_CODE_0 = 2'h0;
  localparam logic [1:0] PCF_CODE_1 = 2'h1;
  localparam logic [1:0] PCF_CODE_2 = 2'h2;
  localparam logic [1:0] PCF_CODE_3 = 2'h3;

  // ----------------------------------------------------------------
  // drive sources: index into i_periph_out / i_periph_oe
  // ----------------------------------------------------------------
  localparam logic [3:0] PCF_S_PRESCALER_CLOCK_OUT = 4'h0;
  localparam logic [3:0] PCF_S_STD_TIMER1_OUT      = 4'h1;
  localparam logic [3:0] PCF_S_STD_TIMER2_OUT      = 4'h2;
  localparam logic [3:0] PCF_S_COMPARATOR0_OUT     = 4'h3;
  localparam logic [3:0] PCF_S_COMPARATOR1_OUT     = 4'h4;
  localparam logic [3:0] PCF_S_COMPACT_TIMER0_OUT  = 4'h5;
  localparam logic [3:0] PCF_S_COMPACT_TIMER1_OUT  = 4'h6;
  localparam logic [3:0] PCF_S_ENH_TIMER_OUT_A     = 4'h7;
  localparam logic [3:0] PCF_S_ENH_TIMER_OUT_B     = 4'h8;
  localparam logic [3:0] PCF_S_SERIAL_B_SELECT     = 4'h9;
  localparam logic [3:0] PCF_S_SERIAL_B_CLOCK      = 4'hA;
  localparam logic [3:0] PCF_S_SERIAL_B_DATA_OUT   = 4'hB;
  localparam logic [3:0] PCF_S_SPI_SDO             = 4'hC;
  localparam logic [3:0] PCF_S_SPI_SCK_I2C_SCL     = 4'hD;
  localparam logic [3:0] PCF_S_SPI_SDI_I2C_SDA     = 4'hE;

  // ----------------------------------------------------------------
  // peripheral inputs: one-hot bits of o_periph_in
  // ----------------------------------------------------------------
  localparam logic [19:0] PCF_M_NONE        = 20'h00000;
  localparam logic [19:0] PCF_M_ST0_CLK     = 20'h00001;
  localparam logic [19:0] PCF_M_ST1_CLK     = 20'h00002;
  localparam logic [19:0] PCF_M_ST2_CLK     = 20'h00004;
  localparam logic [19:0] PCF_M_ST1_CAP     = 20'h00008;
  localparam logic [19:0] PCF_M_ST2_CAP     = 20'h00010;
  localparam logic [19:0] PCF_M_CT0_CLK     = 20'h00020;
  localparam logic [19:0] PCF_M_CT1_CLK     = 20'h00040;
  localparam logic [19:0] PCF_M_ET_CAP_A    = 20'h00080;
  localparam logic [19:0] PCF_M_ET_CAP_B    = 20'h00100;
  localparam logic [19:0] PCF_M_ET_CLK      = 20'h00200;
  localparam logic [19:0] PCF_M_IRQ0        = 20'h00400;
  localparam logic [19:0] PCF_M_IRQ1        = 20'h00800;
  localparam logic [19:0] PCF_M_IRQ2        = 20'h01000;
  localparam logic [19:0] PCF_M_IRQ3        = 20'h02000;
  localparam logic [19:0] PCF_M_PIN_CHANGE  = 20'h04000;
  localparam logic [19:0] PCF_M_SERB_DIN    = 20'h08000;
  localparam logic [19:0] PCF_M_SERB_CLK_IN = 20'h10000;
  localparam logic [19:0] PCF_M_SERB_SEL_IN = 20'h20000;
  localparam logic [19:0] PCF_M_SPI_SCK_IN  = 20'h40000;
  localparam logic [19:0] PCF_M_SPI_SDI_IN  = 20'h80000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PCF_K_GPIO,   // general i/o, plus any shared inputs
    PCF_K_OUT,    // peripheral drives the pin
    PCF_K_IN,     // peripheral digital input only, pin not driven
    PCF_K_ANA,    // comparator analog input, digital path off
    PCF_K_LCD     // lcd segment driver owns the pin
  } pcf_kind_type;

  typedef struct packed {
    pcf_kind_type kind;
    logic [3:0]   src;
    logic [19:0]  inmask;
  } pcf_route_type;

endpackage : pcf_pkg

`default_nettype wire

// *** rtl/pcf_port_select.sv ***
// port c/d/e pin function select: registers, routing of pins to peripherals
`default_nettype none

module pcf_port_select
  import pcf_pkg::*;
#(
  parameter logic [3:0] PC0_LCD_CODES  = 4'h0,  // code c routes pc0 to its segment when bit c set
  parameter logic [3:0] PD0_LCD_CODES  = 4'h0,
  parameter logic [3:0] PE6_LCD_CODES  = 4'h0,
  parameter logic       PC4_CODE3_LCD  = 1'b0
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // avalon-mm slave
  input  wire logic [4:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // pins (three-signal form)
  input  wire logic [PCF_NPINS-1:0] i_pin_in,
  output logic      [PCF_NPINS-1:0] o_pin_out,
  output logic      [PCF_NPINS-1:0] o_pin_oe,
  output logic      [PCF_NPINS-1:0] o_ana_en,
  output logic      [PCF_NPINS-1:0] o_lcd_en,
  // general i/o port logic
  input  wire logic [PCF_NPINS-1:0] i_gpio_out,
  input  wire logic [PCF_NPINS-1:0] i_gpio_oe,
  output logic      [PCF_NPINS-1:0] o_gpio_in,
  // peripherals
  input  wire logic [PCF_NSRC-1:0]  i_periph_out,
  input  wire logic [PCF_NSRC-1:0]  i_periph_oe,
  output logic      [PCF_NIN-1:0]   o_periph_in
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic pcf_route_type mk(input pcf_kind_type kind, input logic [3:0] src,
                                       input logic [19:0] inmask);
    pcf_route_type r;
    r.kind   = kind;
    r.src    = src;
    r.inmask = inmask;
    return r;
  endfunction : mk

  function automatic pcf_route_type gpio(input logic [19:0] inmask);
    return mk(PCF_K_GPIO, 4'h0, inmask);
  endfunction : gpio

  function automatic pcf_route_type drv(input logic [3:0] src, input logic [19:0] inmask);
    return mk(PCF_K_OUT, src, inmask);
  endfunction : drv

  // lcd pin when the code's bit is set in the map, plain io otherwise
  function automatic pcf_route_type lcd_or_io(input logic [3:0] map, input logic [1:0] code);
    return map[code] ? mk(PCF_K_LCD, 4'h0, PCF_M_NONE) : gpio(PCF_M_NONE);
  endfunction : lcd_or_io

  // field code to route; code 3 is the pin's own lcd segment unless stated otherwise
  function automatic pcf_route_type pcf_decode(input logic [4:0] pin, input logic [1:0] code);
    pcf_route_type r;
    r = (code == PCF_CODE_3) ? mk(PCF_K_LCD, 4'h0, PCF_M_NONE) : gpio(PCF_M_NONE);
    unique case (pin)
      5'h00: r = lcd_or_io(PC0_LCD_CODES, code);
      5'h01: begin
        if (code == PCF_CODE_0 || code == PCF_CODE_1) r = gpio(PCF_M_ST2_CLK | PCF_M_PIN_CHANGE);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h02: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ST2_CAP);
        if (code == PCF_CODE_1) r = drv(PCF_S_STD_TIMER2_OUT, PCF_M_NONE);
        if (code == PCF_CODE_2) r = drv(PCF_S_COMPARATOR1_OUT, PCF_M_NONE);
      end
      5'h03: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ST1_CLK);
        if (code == PCF_CODE_1) r = drv(PCF_S_PRESCALER_CLOCK_OUT, PCF_M_NONE);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h04: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ST1_CAP);
        if (code == PCF_CODE_1) r = drv(PCF_S_SERIAL_B_DATA_OUT, PCF_M_NONE);
        if (code == PCF_CODE_2) r = drv(PCF_S_STD_TIMER1_OUT, PCF_M_NONE);
        if (code == PCF_CODE_3) r = lcd_or_io({PC4_CODE3_LCD, 3'h0}, code);
      end
      5'h05: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_CT1_CLK);
        if (code == PCF_CODE_1) r = mk(PCF_K_IN, 4'h0, PCF_M_SERB_DIN);
        if (code == PCF_CODE_2) r = drv(PCF_S_COMPARATOR0_OUT, PCF_M_NONE);
      end
      5'h06: begin
        if (code == PCF_CODE_1) r = drv(PCF_S_SERIAL_B_CLOCK, PCF_M_SERB_CLK_IN);
        if (code == PCF_CODE_2) r = drv(PCF_S_COMPACT_TIMER1_OUT, PCF_M_NONE);
      end
      5'h07: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ST0_CLK);
        if (code == PCF_CODE_1) r = drv(PCF_S_SERIAL_B_SELECT, PCF_M_SERB_SEL_IN);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h08: r = lcd_or_io(PD0_LCD_CODES, code);
      5'h09: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ET_CLK);
        if (code == PCF_CODE_1) r = drv(PCF_S_SPI_SCK_I2C_SCL, PCF_M_SPI_SCK_IN);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h0A: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ET_CAP_B);
        if (code == PCF_CODE_1) r = drv(PCF_S_SPI_SDI_I2C_SDA, PCF_M_SPI_SDI_IN);
        if (code == PCF_CODE_2) r = drv(PCF_S_ENH_TIMER_OUT_B, PCF_M_NONE);
      end
      5'h0B: begin
        if (code == PCF_CODE_1) r = drv(PCF_S_SPI_SDO, PCF_M_NONE);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h0C: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_IRQ3 | PCF_M_CT0_CLK | PCF_M_ET_CAP_A);
        if (code == PCF_CODE_1) r = drv(PCF_S_ENH_TIMER_OUT_A, PCF_M_NONE);
        if (code == PCF_CODE_2) r = drv(PCF_S_COMPARATOR1_OUT, PCF_M_NONE);
      end
      5'h0D: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_IRQ2);
        if (code == PCF_CODE_1) r = drv(PCF_S_COMPACT_TIMER0_OUT, PCF_M_NONE);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h0E: begin
        if (code == PCF_CODE_0 || code == PCF_CODE_1) r = gpio(PCF_M_IRQ1 | PCF_M_ST2_CLK);
        if (code == PCF_CODE_2) r = mk(PCF_K_ANA, 4'h0, PCF_M_NONE);
      end
      5'h0F: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_IRQ0 | PCF_M_ST2_CAP);
        if (code == PCF_CODE_1) r = drv(PCF_S_STD_TIMER2_OUT, PCF_M_NONE);
        if (code == PCF_CODE_2) r = drv(PCF_S_COMPARATOR0_OUT, PCF_M_NONE);
      end
      5'h10: begin
        if (code == PCF_CODE_0 || code == PCF_CODE_2) r = gpio(PCF_M_ST1_CLK);
        if (code == PCF_CODE_1) r = drv(PCF_S_SERIAL_B_DATA_OUT, PCF_M_NONE);
      end
      5'h11: begin
        if (code == PCF_CODE_0) r = gpio(PCF_M_ST1_CAP);
        if (code == PCF_CODE_1) r = mk(PCF_K_IN, 4'h0, PCF_M_SERB_DIN);
        if (code == PCF_CODE_2) r = drv(PCF_S_STD_TIMER1_OUT, PCF_M_NONE);
      end
      5'h16: r = lcd_or_io(PE6_LCD_CODES, code);
      // pe2, pe3, pe4, pe5, pe7 keep the default: io for 0..2, lcd for 3
      default: r = r;
    endcase
    return r;
  endfunction : pcf_decode

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0]           sel_reg [PCF_NSEL];
  logic                 wait_reg;
  logic [31:0]          rdata_reg;
  logic [PCF_NPINS-1:0] pin_meta_reg;
  logic [PCF_NPINS-1:0] pin_level_reg;
  logic [31:0]          rdata_next;

  wire       bus_req    = i_avs_read | i_avs_write;
  wire       bus_take   = bus_req & wait_reg;       // first cycle of a request
  wire       bus_commit = i_avs_write & ~wait_reg;  // edge at which the master sees the answer
  wire [4:0] bus_ofs    = {i_avs_address[4:2], 2'h0};

  // read mux; unmapped offsets read as zero and swallow writes
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus_ofs == PCF_OFS_LEVEL) rdata_next = {8'h00, pin_level_reg};
    for (int k = 0; k < PCF_NSEL; k++) begin
      if (bus_ofs == PCF_OFS_SEL[k]) rdata_next = {24'h00_0000, sel_reg[k]};
    end
  end

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, so read data is always a flop
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~bus_take;
      if (bus_take && i_avs_read) rdata_reg <= rdata_next;
    end
  end

  // select registers; only byte lane 0 holds data
  for (genvar k = 0; k < PCF_NSEL; k++) begin : g_sel
    wire hit = bus_commit & i_avs_byteenable[0] & (bus_ofs == PCF_OFS_SEL[k]);
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sel_reg[k] <= PCF_SEL_RESET;
      end else if (hit) begin
        sel_reg[k] <= i_avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg  <= '0;
      pin_level_reg <= '0;
    end else begin
      pin_meta_reg  <= i_pin_in;
      pin_level_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // per pin routing
  // ----------------------------------------------------------------
  logic [1:0]           fld [PCF_NPINS];
  pcf_route_type        route [PCF_NPINS];
  logic [PCF_NPINS-1:0] out_next;
  logic [PCF_NPINS-1:0] oe_next;
  logic [PCF_NPINS-1:0] ana_next;
  logic [PCF_NPINS-1:0] lcd_next;
  logic [PCF_NIN-1:0]   pin_fed;
  logic [PCF_NIN-1:0]   periph_in_next;

  for (genvar i = 0; i < PCF_NPINS; i++) begin : g_pin
    assign fld[i]   = sel_reg[i / 4][2 * (i % 4) +: 2];
    assign route[i] = pcf_decode(5'(i), fld[i]);
    // analog and lcd pins are never driven digitally, so a stray oe cannot fight the pad
    assign out_next[i] = (route[i].kind == PCF_K_OUT) ? i_periph_out[route[i].src]
                                                       : i_gpio_out[i];
    assign oe_next[i]  = (route[i].kind == PCF_K_OUT)  ? i_periph_oe[route[i].src] :
                         (route[i].kind == PCF_K_GPIO) ? i_gpio_oe[i] : 1'b0;
    assign ana_next[i] = (route[i].kind == PCF_K_ANA);
    assign lcd_next[i] = (route[i].kind == PCF_K_LCD);
  end

  // peripheral inputs: lowest pin wins when two pins claim the same input;
  // the input-source select registers live outside this block
  always_comb begin
    periph_in_next = '0;
    pin_fed        = '0;
    for (int i = 0; i < PCF_NPINS; i++) begin
      for (int j = 0; j < PCF_NIN; j++) begin
        if (route[i].inmask[j] && !pin_fed[j]) begin
          periph_in_next[j] = pin_level_reg[i];
          pin_fed[j]        = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out   <= '0;
      o_pin_oe    <= '0;
      o_ana_en    <= '0;
      o_lcd_en    <= '0;
      o_periph_in <= '0;
    end else begin
      o_pin_out   <= out_next;
      o_pin_oe    <= oe_next;
      o_ana_en    <= ana_next;
      o_lcd_en    <= lcd_next;
      o_periph_in <= periph_in_next;
    end
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata    = rdata_reg;
  assign o_gpio_in         = pin_level_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_taken;
    bus_req && wait_reg;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_a: assert property (s_taken |=> s_answer)
    else $error("bus request not answered after one wait cycle");

  sel_write_a: assert property (
    bus_commit && i_avs_byteenable[0] && bus_ofs == PCF_OFS_SEL[3]
    |=> sel_reg[3] == $past(i_avs_writedata[7:0]) ##1 o_lcd_en[15] == (sel_reg[3][7:6] == 2'h3))
    else $error("written select value not applied");

  pc3_lcd_a: assert property (fld[3] == PCF_CODE_3 |=> o_lcd_en[3] && !o_pin_oe[3])
    else $error("pc3 code 3 did not select its segment");

  pc2_cmp_a: assert property (
    fld[2] == PCF_CODE_2 |=> o_pin_out[2] == $past(i_periph_out[PCF_S_COMPARATOR1_OUT]))
    else $error("pc2 code 2 not driven by comparator 1");

  pc1_ana_a: assert property (
    fld[1] == PCF_CODE_1 |=> !o_ana_en[1] && o_pin_oe[1] == $past(i_gpio_oe[1]))
    else $error("pc1 code 1 not general io");

  pc7_sel_a: assert property (
    fld[7] == PCF_CODE_1 |=> o_pin_oe[7] == $past(i_periph_oe[PCF_S_SERIAL_B_SELECT]))
    else $error("pc7 code 1 not driven by serial select");

  pd6_irq_a: assert property (
    fld[14] != PCF_CODE_2 && fld[14] != PCF_CODE_3
    |=> o_periph_in[11] == $past(pin_level_reg[14]))
    else $error("pd6 level not passed to irq 1");

  pd5_timer_a: assert property (
    fld[13] == PCF_CODE_1 |=> o_pin_out[13] == $past(i_periph_out[PCF_S_COMPACT_TIMER0_OUT]))
    else $error("pd5 code 1 not driven by compact timer 0");

  pe0_serial_a: assert property (
    fld[16] == PCF_CODE_1 |=> o_pin_out[16] == $past(i_periph_out[PCF_S_SERIAL_B_DATA_OUT]))
    else $error("pe0 code 1 not driven by serial data out");

  pe2_io_a: assert property (
    fld[18] != PCF_CODE_3 |=> !o_lcd_en[18] ##0 o_pin_oe[18] == $past(i_gpio_oe[18]))
    else $error("pe2 codes 0 to 2 not general io");

endmodule : pcf_port_select

`default_nettype wire

// *** verif/pcf_port_select_tb_top.sv ***
// self-checking bench for the port c/d/e pin function select block
`default_nettype none
`define CHK(nm, x, y) begin num_checks++; if ((y) !== (x)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, x, y); end end

module pcf_port_select_tb_top import pcf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and dut
  // ----------------------------------------------------------------
  logic                 i_clk            = 1'b0;
  logic                 i_rst            = 1'b1;
  logic [4:0]           i_avs_address    = 5'h00;
  logic                 i_avs_read       = 1'b0;
  logic                 i_avs_write      = 1'b0;
  logic [31:0]          i_avs_writedata  = 32'h00000000;
  logic [3:0]           i_avs_byteenable = 4'hF;
  logic [PCF_NPINS-1:0] i_pin_in         = 24'h000000;
  logic [PCF_NPINS-1:0] i_gpio_out       = 24'h000000;
  logic [PCF_NPINS-1:0] i_gpio_oe        = 24'hFFFFFF;  // io pins show oe high, out low
  logic [PCF_NSRC-1:0]  i_periph_out     = 15'h0000;
  logic [PCF_NSRC-1:0]  i_periph_oe      = 15'h7FFF;
  logic [31:0]          o_avs_readdata;
  logic                 o_avs_waitrequest;
  logic [PCF_NPINS-1:0] o_pin_out, o_pin_oe, o_ana_en, o_lcd_en, o_gpio_in;
  logic [PCF_NIN-1:0]   o_periph_in;
  int                   fail_count = 0;
  int                   num_checks = 0;
  // entry: address, data, pin, kind (0 io 1 out 2 analog 3 lcd 4 input), source
  localparam logic [31:0] TBL [42] = '{
    32'h00400310, 32'h00C00330,
    32'h00100212, 32'h00200214,
    32'h00040100, 32'h00080120,
    32'h04400719, 32'h04800720,
    32'h0410061A, 32'h04200616,
    32'h04040540, 32'h04080513,
    32'h0401041B, 32'h04020411,
    32'h08400B1C, 32'h08C00B30,
    32'h08100A1E, 32'h08200A18,
    32'h0804091D, 32'h08080920,
    32'h0C400F12, 32'h0C800F13,
    32'h0C100E00, 32'h0C200E20,
    32'h0C040D15, 32'h0C080D20,
    32'h0C010C17, 32'h0C020C14,
    32'h10801300, 32'h10C01330,
    32'h10301230,
    32'h10041140, 32'h10081111,
    32'h10021000, 32'h1001101B,
    32'h14C01730, 32'h14401700,
    32'h140C1530,
    32'h14031430, 32'h14021400,
    32'h00030000, 32'h04030400
  };

  pcf_port_select dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_ana_en(o_ana_en), .o_lcd_en(o_lcd_en), .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe), .o_gpio_in(o_gpio_in), .i_periph_out(i_periph_out),
    .i_periph_oe(i_periph_oe), .o_periph_in(o_periph_in));

  always #4 i_clk = ~i_clk;

  // one bus access; waits an edge first so back-to-back calls never collide
  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    i_avs_writedata <= {24'h000000, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 40);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : bus

  // reset values, readback, dropped byte-lane write, unmapped word
  task automatic reg_access_check();
    logic [31:0] q;
    for (int k = 0; k < PCF_NSEL; k++) begin
      bus(PCF_OFS_SEL[k], 1'b0, 8'h00, q);
      `CHK("reset value", {24'h000000, PCF_SEL_RESET}, q)
    end
    bus(5'h04, 1'b1, 8'hA5, q);
    i_avs_byteenable <= 4'hE;
    bus(5'h04, 1'b1, 8'h3C, q);
    i_avs_byteenable <= 4'hF;
    bus(5'h04, 1'b0, 8'h00, q);
    `CHK("readback", 32'h000000A5, q)
    bus(5'h1C, 1'b1, 8'hFF, q);
    bus(5'h1C, 1'b0, 8'h00, q);
    `CHK("unmapped", 32'h00000000, q)
  endtask : reg_access_check

  // one-hot source makes a wrong source selection show as a low pin
  task automatic route_table_check();
    logic [31:0] q, e;
    logic [3:0]  xk, gk;
    for (int i = 0; i < 42; i++) begin
      e = TBL[i];
      // sources go quiet before a field moves and wake only after it is set
      i_periph_out <= 15'h0000;
      bus(e[28:24], 1'b1, e[23:16], q);
      i_periph_out <= 15'h0001 << e[3:0];
      @(posedge i_clk);
      #1;
      xk = {e[7:4] == 4'h1, e[7:4] <= 4'h1, e[7:4] == 4'h2, e[7:4] == 4'h3};
      gk = {o_pin_out[e[15:8]], o_pin_oe[e[15:8]], o_ana_en[e[15:8]], o_lcd_en[e[15:8]]};
      `CHK("route", xk, gk)
    end
  endtask : route_table_check

  // shared input follows the pin in io mode only
  task automatic input_route_check();
    logic [31:0] q;
    bus(5'h00, 1'b1, 8'h00, q);
    i_pin_in <= 24'h000002;
    repeat (5) @(posedge i_clk);
    #1;
    `CHK("pin change in", PCF_M_PIN_CHANGE, o_periph_in & PCF_M_PIN_CHANGE)
    `CHK("gpio in", 24'h000002, o_gpio_in)
    bus(PCF_OFS_LEVEL, 1'b0, 8'h00, q);
    `CHK("pin level reg", 32'h00000002, q)
    bus(5'h00, 1'b1, 8'h08, q);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("pin change off", PCF_M_NONE, o_periph_in & PCF_M_PIN_CHANGE)
  endtask : input_route_check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    reg_access_check();
    route_table_check();
    input_route_check();
    tally_and_finish();
  end
endmodule : pcf_port_select_tb_top
`default_nettype wire
